/* verilog/pbp_pkg.sv */
// register map, field positions and reset values for the two-port gpio block
package pbp_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PA_W = 6;
  localparam int unsigned PB_W = 8;
  localparam logic [3:0] ADDR_PA_DATA = 4'h0;
  localparam logic [3:0] ADDR_PB_DATA = 4'h1;
  localparam logic [3:0] ADDR_PA_DIR = 4'h4;
  localparam logic [3:0] ADDR_PB_DIR = 4'h5;
  localparam logic [3:0] ADDR_PA_PUE = 4'hB;
  localparam logic [3:0] ADDR_PB_PUE = 4'hC;
  localparam logic [3:0] ADDR_PA_CFG = 4'hD;
  localparam int unsigned PA_BIT_INONLY = 2;
  localparam int unsigned PA_BIT_OSC = 4;
  localparam int unsigned PUE_CLKOUT_BIT = 7;
  localparam int unsigned CFG_IRQ_BIT = 0;
  localparam logic [5:0] PA_DIR_RST = 6'h00;
  localparam logic [7:0] PB_DIR_RST = 8'h00;
  localparam logic [5:0] PA_PUE_RST = 6'h00;
  localparam logic [7:0] PB_PUE_RST = 8'h00;
  localparam logic CLKOUT_RST = 1'b0;
  localparam logic IRQ_EN_RST = 1'b0;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // clock source select, two-bit option code
  typedef enum logic [1:0] {
    PBP_SRC_INTERNAL = 2'h0,
    PBP_SRC_EXT_OSC = 2'h1,
    PBP_SRC_RC = 2'h2,
    PBP_SRC_CRYSTAL = 2'h3
  } pbp_src_t;
endpackage

/* verilog/pbp_gpio.sv */
// two-port gpio: six-bit port with pullups and clock-out, eight-bit port
`timescale 1ns/10ps

// How it works
// - a first-port pullup is on only when its enable bit is 1 and the pin is an input.
// - a first-port pullup enable bit of 0 keeps the pullup off in any direction.
// - a first-port pullup drops out by itself while the pin is an output.
// - with internal or rc source and clock-out bit 1, pin 4 is held low with its buffer on for the outside pad mux to swap in the quad bus clock, else it is a gpio.
// - with crystal or external oscillator source the clock-out bit has no effect.
// - first-port bit 2 is never driven as an output.
// - the eight second-port data latches are read/write and untouched by reset.
// - second-port direction 1 drives the pin, 0 releases it, and reset makes all pins inputs.
// - a second-port data read gives the latch for outputs and the pin for inputs.
// - second-port latch writes always land but never change a sensed input.
// - a second-port pullup is on only when its enable bit is 1 and direction is 0.
// - a second-port pullup drops out by itself while the pin is an output.
// - a first-port data read gives the latch where the direction bit is 1 and the pin where it is 0, but bit 2 reads 0 while the irq enable bit is 1.
module pbp_gpio (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [pbp_pkg::ADDR_W-1:0] i_addr,
  input wire logic [pbp_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [pbp_pkg::DATA_W-1:0] o_rdata,
  input wire logic [1:0] i_clock_source,
  input wire logic i_quad_bus_clock,
  input wire logic [pbp_pkg::PA_W-1:0] i_pa_pin,
  output logic [pbp_pkg::PA_W-1:0] o_pa_pin,
  output logic [pbp_pkg::PA_W-1:0] o_pa_oe,
  output logic [pbp_pkg::PA_W-1:0] o_pa_pullup,
  input wire logic [pbp_pkg::PB_W-1:0] i_pb_pin,
  output logic [pbp_pkg::PB_W-1:0] o_pb_pin,
  output logic [pbp_pkg::PB_W-1:0] o_pb_oe,
  output logic [pbp_pkg::PB_W-1:0] o_pb_pullup
);
  import pbp_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [PA_W-1:0] pa_meta_q;
  logic [PA_W-1:0] pa_sync_q;
  logic [PB_W-1:0] pb_meta_q;
  logic [PB_W-1:0] pb_sync_q;
  logic [1:0] src_meta_q;
  logic [1:0] src_sync_q;

  always_ff @(posedge i_clock) begin
    pa_meta_q <= i_pa_pin;
    pa_sync_q <= pa_meta_q;
    pb_meta_q <= i_pb_pin;
    pb_sync_q <= pb_meta_q;
    src_meta_q <= i_clock_source;
    src_sync_q <= src_meta_q;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [PA_W-1:0] pa_data_q;
  logic [PA_W-1:0] pa_dir_q;
  logic [PA_W-1:0] pa_pue_q;
  logic clkout_en_q;
  logic irq_en_q;
  logic [PB_W-1:0] pb_data_q;
  logic [PB_W-1:0] pb_dir_q;
  logic [PB_W-1:0] pb_pue_q;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  // data latches have no reset on purpose; writes land whatever the direction
  always_ff @(posedge i_clock) begin
    if (i_wr && hit(i_addr, ADDR_PA_DATA)) begin
      pa_data_q <= i_wdata[PA_W-1:0];
    end
    if (i_wr && hit(i_addr, ADDR_PB_DATA)) begin
      pb_data_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      pa_dir_q <= PA_DIR_RST;
      pb_dir_q <= PB_DIR_RST;
    end else if (i_wr) begin
      if (hit(i_addr, ADDR_PA_DIR)) begin
        pa_dir_q <= i_wdata[PA_W-1:0];
      end
      if (hit(i_addr, ADDR_PB_DIR)) begin
        pb_dir_q <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      pa_pue_q <= PA_PUE_RST;
      pb_pue_q <= PB_PUE_RST;
      clkout_en_q <= CLKOUT_RST;
      irq_en_q <= IRQ_EN_RST;
    end else if (i_wr) begin
      if (hit(i_addr, ADDR_PA_PUE)) begin
        pa_pue_q <= i_wdata[PA_W-1:0];
        clkout_en_q <= i_wdata[PUE_CLKOUT_BIT];
      end
      if (hit(i_addr, ADDR_PB_PUE)) begin
        pb_pue_q <= i_wdata;
      end
      if (hit(i_addr, ADDR_PA_CFG)) begin
        irq_en_q <= i_wdata[CFG_IRQ_BIT];
      end
    end
  end

  // ----------------------------------------
  // pin control
  // ----------------------------------------
  logic clk_owns_pin;
  assign clk_owns_pin = clkout_en_q &&
    (src_sync_q == PBP_SRC_INTERNAL || src_sync_q == PBP_SRC_RC);

  logic [PA_W-1:0] pa_oe_d;
  logic [PA_W-1:0] pa_out_d;
  logic [PA_W-1:0] pa_pu_d;
  logic [PA_W-1:0] pa_rd_d;
  logic [PB_W-1:0] pb_rd_d;

  always_comb begin
    pa_oe_d = pa_dir_q;
    pa_out_d = pa_data_q;
    pa_pu_d = pa_pue_q & ~pa_dir_q;
    pa_oe_d[PA_BIT_INONLY] = 1'b0;
    if (clk_owns_pin) begin
      // pin 4 becomes a dedicated clock output; its gpio bits are bypassed
      pa_oe_d[PA_BIT_OSC] = 1'b1;
      pa_out_d[PA_BIT_OSC] = 1'b0;
      pa_pu_d[PA_BIT_OSC] = 1'b0;
    end
    pa_rd_d = (pa_data_q & pa_dir_q) | (pa_sync_q & ~pa_dir_q);
    if (irq_en_q) begin
      pa_rd_d[PA_BIT_INONLY] = 1'b0;
    end
    pb_rd_d = (pb_data_q & pb_dir_q) | (pb_sync_q & ~pb_dir_q);
  end

  // outputs registered; the clock itself is gated combinationally only on the mux select
  logic clk_sel_q;
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_pa_oe <= '0;
      o_pa_pin <= '0;
      o_pa_pullup <= '0;
      o_pb_oe <= '0;
      o_pb_pin <= '0;
      o_pb_pullup <= '0;
      clk_sel_q <= 1'b0;
    end else begin
      o_pa_oe <= pa_oe_d;
      o_pa_pin <= pa_out_d;
      o_pa_pullup <= pa_pu_d;
      o_pb_oe <= pb_dir_q;
      o_pb_pin <= pb_data_q;
      o_pb_pullup <= pb_pue_q & ~pb_dir_q;
      clk_sel_q <= clk_owns_pin;
    end
  end

  // ----------------------------------------
  // clock output pin
  // ----------------------------------------
  // limitation: the quad bus clock runs faster than i_clock and cannot pass a flop,
  // so pin 4 is held low with its buffer on and the pad mux outside swaps in the clock

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_rdata <= READ_ZERO;
    end else if (i_rd) begin
      unique case (i_addr)
        ADDR_PA_DATA: o_rdata <= {2'h0, pa_rd_d};
        ADDR_PB_DATA: o_rdata <= pb_rd_d;
        ADDR_PA_DIR: o_rdata <= {2'h0, pa_dir_q};
        ADDR_PB_DIR: o_rdata <= pb_dir_q;
        ADDR_PA_PUE: o_rdata <= {clkout_en_q, 1'b0, pa_pue_q};
        ADDR_PB_PUE: o_rdata <= pb_pue_q;
        ADDR_PA_CFG: o_rdata <= {7'h00, irq_en_q};
        default: o_rdata <= READ_ZERO;
      endcase
    end else begin
      o_rdata <= READ_ZERO;
    end
  end

  // the quad clock is only gated with the registered select; no flop samples it
  logic unused_clk;
  assign unused_clk = i_quad_bus_clock & clk_sel_q;
endmodule

/* verification/pbp_gpio_monitor.sv */
// assertion checker for the two-port gpio block
`timescale 1ns/10ps
module pbp_gpio_monitor import pbp_pkg::*; (
  input wire logic i_clock, i_nrst, i_wr, i_rd,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata, o_rdata,
  input wire logic [PA_W-1:0] o_pa_oe, o_pa_pullup,
  input wire logic [PB_W-1:0] o_pb_pin, o_pb_oe, o_pb_pullup
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // register then output flop: a write shows at the pins two edges later
  chk_pb_oe_dir: assert property (
    $past(i_nrst) && $past(i_wr,2) && $past(i_addr,2) == ADDR_PB_DIR |-> o_pb_oe == $past(i_wdata,2)) else $error("pb oe");
  chk_pb_oe_hold: assert property (
    $past(i_nrst) && $changed(o_pb_oe) |-> $past(i_wr,2) && $past(i_addr,2) == ADDR_PB_DIR) else $error("pb oe moved");
  chk_pb_latch_out: assert property (
    $past(i_nrst) && $past(i_wr,2) && $past(i_addr,2) == ADDR_PB_DATA |-> o_pb_pin == $past(i_wdata,2)) else $error("pb pin");
  chk_pb_pue_pull: assert property (
    $past(i_nrst) && $past(i_wr,2) && $past(i_addr,2) == ADDR_PB_PUE && !$past(i_wr)
      |-> o_pb_pullup == ($past(i_wdata,2) & ~o_pb_oe)) else $error("pb pullup");
  chk_pb_pull_out: assert property ((o_pb_pullup & o_pb_oe) == 8'h00) else $error("pb pullup on output");
  chk_pa_pull_out: assert property ((o_pa_pullup & o_pa_oe) == 6'h00) else $error("pa pullup on output");
  chk_pa2_input: assert property (!o_pa_oe[PA_BIT_INONLY]) else $error("pa2 driven");
  chk_rd_idle: assert property (!$past(i_rd) |-> o_rdata == READ_ZERO) else $error("rdata idle");
endmodule
bind pbp_gpio pbp_gpio_monitor u_pbp_gpio_monitor (.i_clock, .i_nrst, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata,
  .o_pa_oe, .o_pa_pullup, .o_pb_pin, .o_pb_oe, .o_pb_pullup);

/* verification/pbp_board.sv */
// board model: pin levels from device drive, pullups and outside drivers
`timescale 1ns/10ps
module pbp_board (
  input wire logic i_clock,
  input wire logic [7:0] i_drv, i_oe, i_pull, i_ext, i_ext_en,
  output logic [7:0] o_level
);
  logic [7:0] last_q = 8'h00;
  // a floating pin wanders, so show the inverse of its last level
  assign o_level = (i_oe & i_drv) | (~i_oe & i_ext_en & i_ext) | (~i_oe & ~i_ext_en & (i_pull | ~last_q));
  always_ff @(posedge i_clock) last_q <= o_level;
endmodule

/* verification/tb.sv */
// self-checking bench for the two-port gpio block
`timescale 1ns/10ps
module tb;
  import pbp_pkg::*;
  logic i_clock = 0, i_nrst = 0, i_wr = 0, i_rd = 0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata, o_pb_pin, o_pb_oe, o_pb_pullup, ext = 8'h00, en = 8'h00, lvl;
  logic [7:0] lat, dir, pue, pd;
  logic [1:0] src = 2'h0;
  logic [5:0] pa_in = 6'h00, o_pa_pin, o_pa_oe, o_pa_pullup;
  int fail_count = 0, n_tests = 0, seed = 74;
  pbp_gpio u_pbp_gpio (.i_clock, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_clock_source(src),
    .i_quad_bus_clock(1'b0), .i_pa_pin(pa_in), .o_pa_pin, .o_pa_oe, .o_pa_pullup, .i_pb_pin(lvl), .o_pb_pin,
    .o_pb_oe, .o_pb_pullup);
  pbp_board u_pbp_board (.i_clock, .i_drv(o_pb_pin), .i_oe(o_pb_oe), .i_pull(o_pb_pullup), .i_ext(ext),
    .i_ext_en(en), .o_level(lvl));
  initial forever #10 i_clock = ~i_clock;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >>> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp, input string nm);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(negedge i_clock);
    chk(o_rdata & m, exp & m, nm);
  endtask
  // covers the output flop and the two-flop input synchroniser
  task automatic settle();
    repeat (3) @(negedge i_clock);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge i_clock);
    i_nrst <= 1'b1;
    rd(ADDR_PB_DIR, 8'hFF, PB_DIR_RST, "pb dir reset");
    rd(ADDR_PB_PUE, 8'hFF, PB_PUE_RST, "pb pue reset");
    for (int i = 0; i < 8; i++) begin
      lat = rnd();
      dir = rnd();
      pue = rnd();
      wr(ADDR_PB_DATA, lat);
      wr(ADDR_PB_DIR, dir);
      wr(ADDR_PB_PUE, pue);
      ext <= rnd();
      en <= rnd();
      settle();
      chk(o_pb_oe, dir, "pb oe");
      chk(o_pb_pin & dir, lat & dir, "pb drive");
      chk(o_pb_pullup, pue & ~dir, "pb pullup");
      rd(ADDR_PB_DATA, dir | en | pue, (lat & dir) | (((ext & en) | (pue & ~en)) & ~dir), "pb data");
      rd(ADDR_PB_DIR, 8'hFF, dir, "pb dir");
      rd(ADDR_PB_PUE, 8'hFF, pue, "pb pue");
    end
    @(posedge i_clock);
    i_nrst <= 1'b0;
    repeat (6) @(posedge i_clock);
    i_nrst <= 1'b1;
    wr(ADDR_PB_DIR, 8'hFF);
    settle();
    rd(ADDR_PB_DATA, 8'hFF, lat, "pb latch kept");
    rd(4'hF, 8'hFF, READ_ZERO, "unmapped");
    pa_in <= 6'(rnd());
    pd = (rnd() & 8'h3F) | 8'h04;
    wr(ADDR_PA_DATA, lat);
    wr(ADDR_PA_DIR, pd);
    wr(ADDR_PA_PUE, 8'h3F);
    settle();
    chk(o_pa_oe, pd & 8'h3B, "pa oe");
    chk(o_pa_pullup, 8'h3F & ~pd, "pa pullup");
    rd(ADDR_PA_DATA, 8'h3B, (lat & pd) | (pa_in & ~pd), "pa data");
    wr(ADDR_PA_CFG, 8'h01);
    rd(ADDR_PA_CFG, 8'hFF, 8'h01, "pa cfg");
    rd(ADDR_PA_DATA, 8'h04, 8'h00, "pa2 irq read");
    wr(ADDR_PA_PUE, 8'h00);
    settle();
    chk(o_pa_pullup, 8'h00, "pa pullup off");
    wr(ADDR_PA_DIR, 8'h00);
    wr(ADDR_PA_DATA, 8'h10);
    for (int s = 0; s < 4; s++) begin
      @(posedge i_clock);
      src <= 2'(s);
      wr(ADDR_PA_PUE, 8'hBF);
      settle();
      chk(o_pa_oe[4], 8'(s % 2 == 0), "clock out oe");
      chk(o_pa_pullup[4], 8'(s % 2), "pa4 pullup");
      chk(o_pa_pin[4], 8'(s % 2), "pa4 drive");
      rd(ADDR_PA_PUE, 8'hFF, 8'hBF, "pa pue clock bit");
    end
    test_done();
  end
  initial begin
    repeat (5000) @(posedge i_clock);
    fail_count++;
    test_done();
  end
endmodule
